// *** muxed_io_port.v ***
// Purpose: Three-bit general-purpose port with on-chip function muxing
// Assumes: Plain register port, read data one cycle after read strobe
// Notes:   Pull-ups and input buffers are pad controls driven out
//          Pin one: the clock output outranks the alarm select
//          Data reads show synchronised pin levels, not written data
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "muxed_port_regs.vh"
module muxed_io_port
#(
  parameter WIDTH = `PORT_WIDTH
)
(
  input  wire              clk,
  input  wire              rst,
  input  wire [7:0]        addr,
  input  wire [31:0]       wrData,
  input  wire              wrStrobe,
  input  wire              rdStrobe,
  output reg  [31:0]       rdData,
  input  wire [WIDTH-1:0]  pinIn,
  output wire [WIDTH-1:0]  pinOut,
  output wire [WIDTH-1:0]  pinOe,
  output reg  [WIDTH-1:0]  pullupOn,
  output reg  [WIDTH-1:0]  inputOn,
  input  wire              timerNineOutput,
  input  wire              systemClockOutput,
  input  wire              alarmOutput,
  input  wire              controlLineOut,
  output reg               controlLineIn
);
  // Stored control bits
  reg  [WIDTH-1:0] portPinData_r;
  reg  [WIDTH-1:0] portOutputEnable_r;
  reg  [WIDTH-1:0] portFunctionSelectOne_r;
  reg              alarmOutSelect_r;
  reg  [WIDTH-1:0] portPullupEnable_r;
  reg  [WIDTH-1:0] portInputEnable_r;

  // Next values
  reg  [WIDTH-1:0] portPinData_nxt;
  reg  [WIDTH-1:0] portOutputEnable_nxt;
  reg  [WIDTH-1:0] portFunctionSelectOne_nxt;
  reg              alarmOutSelect_nxt;
  reg  [WIDTH-1:0] portPullupEnable_nxt;
  reg  [WIDTH-1:0] portInputEnable_nxt;
  reg  [31:0]      rdData_nxt;
  reg  [WIDTH-1:0] pullupOn_nxt;
  reg  [WIDTH-1:0] inputOn_nxt;
  reg              controlLineIn_nxt;
  reg              pinOneSource;

  // Decode and routing nets
  wire [WIDTH-1:0] pinLevel;
  wire [WIDTH-1:0] funcSel;
  wire [WIDTH-1:0] funcVal;
  wire [WIDTH-1:0] dataView;
  wire             hitPinData;
  wire             hitOutputEnable;
  wire             hitFuncSelOne;
  wire             hitFuncSelTwo;
  wire             hitPullupEnable;
  wire             hitInputEnable;
  wire             hitAny;

  // Address decode, one hit line per register
  assign hitPinData      = (addr == `OFS_PIN_DATA);
  assign hitOutputEnable = (addr == `OFS_OUTPUT_ENABLE);
  assign hitFuncSelOne   = (addr == `OFS_FUNC_SEL_ONE);
  assign hitFuncSelTwo   = (addr == `OFS_FUNC_SEL_TWO);
  assign hitPullupEnable = (addr == `OFS_PULLUP_ENABLE);
  assign hitInputEnable  = (addr == `OFS_INPUT_ENABLE);
  assign hitAny          = hitPinData
                         | hitOutputEnable
                         | hitFuncSelOne
                         | hitFuncSelTwo
                         | hitPullupEnable
                         | hitInputEnable;

  // Next register values; a write touches only the register it hits
  always @*
  begin
    portPinData_nxt           = portPinData_r;
    portOutputEnable_nxt      = portOutputEnable_r;
    portFunctionSelectOne_nxt = portFunctionSelectOne_r;
    alarmOutSelect_nxt        = alarmOutSelect_r;
    portPullupEnable_nxt      = portPullupEnable_r;
    portInputEnable_nxt       = portInputEnable_r;
    if (wrStrobe)
    begin
      if (hitPinData)
      begin
        portPinData_nxt = wrData[WIDTH-1:0];
      end
      if (hitOutputEnable)
      begin
        portOutputEnable_nxt = wrData[WIDTH-1:0];
      end
      if (hitFuncSelOne)
      begin
        portFunctionSelectOne_nxt = wrData[WIDTH-1:0];
      end
      // Only the alarm bit exists; the rest stay zero
      if (hitFuncSelTwo)
      begin
        alarmOutSelect_nxt = wrData[`FSEL2_ALARM_BIT];
      end
      // Pin zero has no pull-up, so its bit is masked off
      if (hitPullupEnable)
      begin
        portPullupEnable_nxt = wrData[WIDTH-1:0] & `PULLUP_MASK;
      end
      if (hitInputEnable)
      begin
        portInputEnable_nxt = wrData[WIDTH-1:0];
      end
    end
  end

  // Register update; all controls clear on reset
  always @(posedge clk)
  begin
    if (rst)
    begin
      portPinData_r           <= `RESET_VALUE_3;
      portOutputEnable_r      <= `RESET_VALUE_3;
      portFunctionSelectOne_r <= `RESET_VALUE_3;
      alarmOutSelect_r        <= 1'b0;
      portPullupEnable_r      <= `RESET_VALUE_3;
      portInputEnable_r       <= `RESET_VALUE_3;
    end
    else
    begin
      portPinData_r           <= portPinData_nxt;
      portOutputEnable_r      <= portOutputEnable_nxt;
      portFunctionSelectOne_r <= portFunctionSelectOne_nxt;
      alarmOutSelect_r        <= alarmOutSelect_nxt;
      portPullupEnable_r      <= portPullupEnable_nxt;
      portInputEnable_r       <= portInputEnable_nxt;
    end
  end

  // Pin inputs cross into the clock domain through four flops
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : syncs
      pin_sync u_sync
      (
        .clk   (clk),
        .rst   (rst),
        .pinIn (pinIn[g]),
        .level (pinLevel[g])
      );
    end
  endgenerate

  // Clock output outranks the alarm when both selects are set
  always @*
  begin
    if (portFunctionSelectOne_r[1])
    begin
      pinOneSource = systemClockOutput;
    end
    else
    begin
      pinOneSource = alarmOutput;
    end
  end

  // Function selects; alarm shares pin one with the clock output
  assign funcSel[0] = portFunctionSelectOne_r[0];
  assign funcSel[1] = portFunctionSelectOne_r[1] | alarmOutSelect_r;
  assign funcSel[2] = portFunctionSelectOne_r[2];

  // Values each pin carries when its select is set
  assign funcVal[0] = controlLineOut;
  assign funcVal[1] = pinOneSource;
  assign funcVal[2] = timerNineOutput;

  // One driver per pin, pin zero open drain
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : drivers
      pin_driver
      #(
        .OPEN_DRAIN ((g == `OPEN_DRAIN_PIN) ? 1 : 0)
      )
      u_drv
      (
        .clk        (clk),
        .rst        (rst),
        .portData   (portPinData_r[g]),
        .outEnable  (portOutputEnable_r[g]),
        .funcSelect (funcSel[g]),
        .funcValue  (funcVal[g]),
        .padOut     (pinOut[g]),
        .padOe      (pinOe[g])
      );
    end
  endgenerate

  // Disabled input buffers read as zero so floating pins stay quiet
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : views
      assign dataView[g] = pinLevel[g] & portInputEnable_r[g];
    end
  endgenerate

  // Read mux; unmapped offsets and upper bits read as zero
  always @*
  begin
    rdData_nxt = 32'h00000000;
    case (addr)
      `OFS_PIN_DATA:
      begin
        rdData_nxt[WIDTH-1:0] = dataView;
      end
      `OFS_OUTPUT_ENABLE:
      begin
        rdData_nxt[WIDTH-1:0] = portOutputEnable_r;
      end
      `OFS_FUNC_SEL_ONE:
      begin
        rdData_nxt[WIDTH-1:0] = portFunctionSelectOne_r;
      end
      `OFS_FUNC_SEL_TWO:
      begin
        rdData_nxt[`FSEL2_ALARM_BIT] = alarmOutSelect_r;
      end
      `OFS_PULLUP_ENABLE:
      begin
        rdData_nxt[WIDTH-1:0] = portPullupEnable_r;
      end
      `OFS_INPUT_ENABLE:
      begin
        rdData_nxt[WIDTH-1:0] = portInputEnable_r;
      end
      default:
      begin
        rdData_nxt = 32'h00000000;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rst)
    begin
      rdData <= 32'h00000000;
    end
    else if (rdStrobe && hitAny)
    begin
      rdData <= rdData_nxt;
    end
    else
    begin
      rdData <= 32'h00000000;
    end
  end

  // Next pad controls; pin zero never gets a pull-up
  always @*
  begin
    pullupOn_nxt      = portPullupEnable_r & `PULLUP_MASK;
    inputOn_nxt       = portInputEnable_r;
    controlLineIn_nxt = pinLevel[0] & portInputEnable_r[0];
  end

  // Pad controls; pull-ups forced off in reset
  always @(posedge clk)
  begin
    if (rst)
    begin
      pullupOn      <= `RESET_VALUE_3;
      inputOn       <= `RESET_VALUE_3;
      controlLineIn <= 1'b0;
    end
    else
    begin
      pullupOn      <= pullupOn_nxt;
      inputOn       <= inputOn_nxt;
      controlLineIn <= controlLineIn_nxt;
    end
  end
endmodule
`default_nettype wire

// *** muxed_port_regs.vh ***
// Purpose: Register map and constants for the three-bit muxed I/O port
// Assumes: Word-aligned byte offsets relative to the port base address
// Notes:   Definitions only
`ifndef MUXED_PORT_REGS_VH
`define MUXED_PORT_REGS_VH

`define PORT_BASE_ADDR      32'h40000280
`define OFS_PIN_DATA        8'h00
`define OFS_OUTPUT_ENABLE   8'h04
`define OFS_FUNC_SEL_ONE    8'h08
`define OFS_FUNC_SEL_TWO    8'h0c
`define OFS_PULLUP_ENABLE   8'h2c
`define OFS_INPUT_ENABLE    8'h38
`define PORT_WIDTH          3
`define RESET_VALUE_3       3'h0
`define FSEL2_ALARM_BIT     1
`define PULLUP_MASK         3'h6
`define OPEN_DRAIN_PIN      0

`endif

// *** pin_sync.v ***
// Purpose: Three-flop synchroniser plus filtered output flop for one pin input
// Assumes: Asynchronous pin level, single clock
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
  input  wire clk,
  input  wire rst,
  input  wire pinIn,
  output reg  level
);
  reg stageOne_r;
  reg stageTwo_r;
  reg stageThree_r;

  // Stage one feeds only stage two to limit metastability
  always @(posedge clk)
  begin
    if (rst)
    begin
      stageOne_r   <= 1'b0;
      stageTwo_r   <= 1'b0;
      stageThree_r <= 1'b0;
      level        <= 1'b0;
    end
    else
    begin
      stageOne_r   <= pinIn;
      stageTwo_r   <= stageOne_r;
      stageThree_r <= stageTwo_r;
      if (stageTwo_r == stageThree_r)
        level <= stageThree_r;
    end
  end
endmodule
`default_nettype wire

// *** pin_driver.v ***
// Purpose: Output mux and pad control for one port pin
// Assumes: Function source and control bits from the same clock
// Notes:   Open-drain option never drives a high level
`timescale 1ns/1ps
`default_nettype none
module pin_driver
#(
  parameter OPEN_DRAIN = 0
)
(
  input  wire clk,
  input  wire rst,
  input  wire portData,
  input  wire outEnable,
  input  wire funcSelect,
  input  wire funcValue,
  output reg  padOut,
  output reg  padOe
);
  wire driveValue;

  // Function source takes over the pin when selected
  assign driveValue = funcSelect ? funcValue : portData;

  // Registered pad controls; open drain only pulls low
  always @(posedge clk)
  begin
    if (rst)
    begin
      padOut <= 1'b0;
      padOe  <= 1'b0;
    end
    else if (OPEN_DRAIN != 0)
    begin
      padOut <= 1'b0;
      padOe  <= outEnable & ~driveValue;
    end
    else
    begin
      padOut <= driveValue;
      padOe  <= outEnable;
    end
  end
endmodule
`default_nettype wire

// *** port_checker.sv ***
// Purpose: Port-level assertions for the muxed I/O port
// Assumes: Registered outputs, read data one cycle after strobe
// Notes:   Attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module port_checker
#(
  parameter WIDTH = 3
)
(
  input wire logic             clk,
  input wire logic             rst,
  input wire logic [7:0]       addr,
  input wire logic [31:0]      wrData,
  input wire logic             wrStrobe,
  input wire logic [31:0]      rdData,
  input wire logic             rdStrobe,
  input wire logic [WIDTH-1:0] pinOut,
  input wire logic [WIDTH-1:0] pinOe,
  input wire logic [WIDTH-1:0] pullupOn,
  input wire logic [WIDTH-1:0] inputOn,
  input wire logic             controlLineIn
);
  logic pullWr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Pull-up writes, the only legal cause besides reset of a pull-up change
  assign pullWr = wrStrobe && addr == 8'h2c;
  od_never_high_a: assert property (pinOut[0] == 1'b0)
    else $error("pin zero drove high");
  pull_bit_zero_a: assert property (pullupOn[0] == 1'b0)
    else $error("pin zero pull-up on");
  rd_upper_zero_a: assert property (rdData[31:3] == 29'h0)
    else $error("upper read bits set");
  rd_idle_zero_a: assert property (!$past(rdStrobe) |-> rdData == 0)
    else $error("read data outside read slot");
  reset_clear_a: assert property ($fell(rst) |->
    pinOe == 0 && pullupOn == 0 && inputOn == 0)
    else $error("controls not cleared by reset");
  oe_write_a: assert property ((wrStrobe && addr == 8'h04)
    ##1 !wrStrobe |=> pinOe[2:1] == $past(wrData[2:1], 2))
    else $error("output enable not applied");
  in_gate_a: assert property (!inputOn[0] && !$past(inputOn[0])
    |-> !controlLineIn)
    else $error("control line passed with input off");
  pull_cause_a: assert property ($changed(pullupOn) |->
    $past(rst) || $past(rst, 2) || $past(pullWr) || $past(pullWr, 2))
    else $error("pull-up changed without a write");
endmodule
bind muxed_io_port port_checker #(.WIDTH(WIDTH)) u_chk (.clk(clk),
  .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
  .rdData(rdData), .rdStrobe(rdStrobe), .pinOut(pinOut), .pinOe(pinOe),
  .pullupOn(pullupOn), .inputOn(inputOn), .controlLineIn(controlLineIn));
`default_nettype wire

// *** pin_partner.sv ***
// Purpose: Pad side: pull-ups, outside drivers, floating lines
// Assumes: Bench never drives a pin the port drives
// Notes:   Floating lines toggle so stale levels never read back
`timescale 1ns/1ps
`default_nettype none
module pin_partner
(
  input  wire logic       clk,
  input  wire logic [2:0] pinOut,
  input  wire logic [2:0] pinOe,
  input  wire logic [2:0] pullupOn,
  input  wire logic [2:0] extLevel,
  input  wire logic [2:0] extDrive,
  output var  logic [2:0] pinLevel
);
  logic flt = 1'b0;
  // Undriven, unpulled line wanders each cycle
  always @(posedge clk) flt <= ~flt;
  // Port wins; pin zero only ever pulls low
  always_comb
    for (int i = 0; i < 3; i++)
      pinLevel[i] = pinOe[i] ? pinOut[i] : extDrive[i] ? extLevel[i]
                  : pullupOn[i] ? 1'b1 : flt;
endmodule
`default_nettype wire

// *** muxed_io_port_tb.sv ***
// Purpose: Self-checking bench for the muxed I/O port
// Assumes: One-cycle strobes, read data in the following cycle
// Notes:   Pin levels come from the partner model
`timescale 1ns/1ps
`default_nettype none
module muxed_io_port_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wrData = 32'h0;
  logic        wrStrobe = 1'b0;
  logic        rdStrobe = 1'b0;
  logic [31:0] rdData;
  logic [31:0] rdVal;
  logic [2:0]  pinIn, pinOut, pinOe, pullupOn, inputOn;
  logic [2:0]  extLevel = 3'h7;
  logic [2:0]  extDrive = 3'h0;
  logic [3:0]  fn = 4'h0; // timer, clock, alarm, control line
  logic        controlLineIn;
  int          errTotal = 0, numChecks = 0, cyc = 0;
  logic [7:0]  ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h2c, 8'h38};
  logic [31:0] msk [6] = '{32'h0, 32'h7, 32'h7, 32'h2, 32'h6, 32'h7};
  always #2.5 clk = ~clk;
  muxed_io_port u_dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullupOn(pullupOn),
    .inputOn(inputOn), .timerNineOutput(fn[3]), .systemClockOutput(fn[2]),
    .alarmOutput(fn[1]), .controlLineOut(fn[0]),
    .controlLineIn(controlLineIn));
  pin_partner u_pins (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
    .pullupOn(pullupOn), .extLevel(extLevel), .extDrive(extDrive),
    .pinLevel(pinIn));
  task automatic end_sim;
    if (errTotal == 0 && numChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    numChecks++;
    if (g !== e)
    begin
      errTotal++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 rdVal = rdData;
  endtask
  // Settle time: write, sync chain, registered read
  task automatic idle;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 6; i++)
    begin
      rd(ofs[i]);
      chk("reset value", 32'h0, rdVal);
    end
  endtask
  task automatic t_regs;
    for (int i = 1; i < 6; i++)
    begin
      wr(ofs[i], 32'hffffffff);
      rd(ofs[i]);
      chk("reg mask", msk[i], rdVal);
    end
    wr(8'h10, 32'hffffffff);
    rd(8'h10);
    chk("unmapped", 32'h0, rdVal);
    chk("pad pulls", 32'h6, {29'h0, pullupOn});
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h0);
  endtask
  task automatic t_pins;
    wr(8'h00, 32'h6);
    idle;
    chk("pin oe", 32'h7, {29'h0, pinOe});
    rd(8'h00);
    chk("pin read", 32'h6, rdVal);
    wr(8'h00, 32'h1);
    extDrive <= 3'h1;
    idle;
    chk("od release", 32'h6, {29'h0, pinOe});
    chk("ctl in", 32'h1, {31'h0, controlLineIn});
    rd(8'h00);
    chk("pin read", 32'h1, rdVal);
    wr(8'h38, 32'h6);
    idle;
    chk("pad inputs", 32'h6, {29'h0, inputOn});
    rd(8'h00);
    chk("input off", 32'h0, rdVal);
    wr(8'h04, 32'h0);
    idle;
    rd(8'h00);
    chk("pulled high", 32'h6, rdVal);
  endtask
  task automatic t_func;
    wr(8'h04, 32'h7);
    extDrive <= 3'h0;
    fn <= 4'ha;
    wr(8'h08, 32'h7);
    idle;
    chk("func out", 32'h2, {30'h0, pinOut[2:1]});
    chk("ctl low", 32'h7, {29'h0, pinOe});
    wr(8'h08, 32'h5);
    wr(8'h0c, 32'h2);
    fn <= 4'hb;
    idle;
    chk("alarm out", 32'h3, {30'h0, pinOut[2:1]});
    chk("ctl free", 32'h6, {29'h0, pinOe});
  endtask
  task automatic t_rerst;
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("pull in rst", 32'h0, {29'h0, pullupOn});
    @(posedge clk) rst <= 1'b0;
    t_reset;
  endtask
  // Cycle ceiling against a hung bus wait
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errTotal++;
      end_sim;
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_pins;
    t_func;
    t_rerst;
    end_sim;
  end
endmodule
`default_nettype wire
